// ### dv/adc_sweep_sequencer_bench.sv
// Self-checking bench for the sweep sequencer over APB.
// Assumes one wait state per APB access and a 20 MHz pclk.
`timescale 1ns/1ns
module adc_sweep_sequencer_bench;
	import adc_seq_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, trig, pready, pslverr;
	logic conv_sample, conv_busy, irq;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [RES_W-1:0] conv_code;
	logic [RES_W-1:0] codes [8];
	logic [CH_W-1:0] chsel;
	logic [32:0] expq [$];
	int err_count, total_checks, c, s, smp;
	int dv [6] = '{1, 2, 3, 4, 6, 12};
	// Indexed by {sample-hold, 10-bit}
	int nn [4] = '{49, 59, 28, 33};

	adc_sweep_sequencer dut_u (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.external_conversion_trigger(trig), .conv_code(conv_code),
		.analog_channel_sel(chsel), .conv_sample(conv_sample), .conv_busy(conv_busy),
		.irq(irq));
	analog_front_model front_u (.analog_channel_sel(chsel), .chan_code(codes),
		.conv_code(conv_code));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task automatic print_verdict;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk_rd(input logic [32:0] got, input logic [32:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Small slack for pipeline lag at each end
	task automatic chk_cnt(input int got, input int exp);
		total_checks++;
		if (got < exp - 2 || got > exp + 2) begin
			err_count++;
			$display("wrong value at %0t: %0d cycles, expected %0d", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e);
		expq.push_back({e, d});
		apb(1'b0, a, 32'h0000_0000);
	endtask

	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
			if (expq.size() == 0) begin
				err_count++;
				$display("wrong value at %0t: read with no expectation", $time);
			end else begin
				chk_rd({pslverr, prdata}, expq.pop_front());
			end
		end
	end

	function automatic logic [31:0] ctrl(input logic [2:0] ch, input logic [2:0] md,
		input logic ext, input logic [2:0] fr, input logic r10, input logic sh,
		input logic [1:0] g);
		ctrl = 32'h0000_0000;
		ctrl[F_CHAN +: CH_W] = ch;
		ctrl[F_MODE +: MODE_W] = md;
		ctrl[F_START] = 1'b1;
		ctrl[F_EXT] = ext;
		ctrl[F_FREQ +: FREQ_W] = fr;
		ctrl[F_RES10] = r10;
		ctrl[F_SH] = sh;
		ctrl[F_SWEEP +: SWEEP_W] = g;
	endfunction

	function automatic logic [31:0] rexp(input int ch, input logic r10);
		rexp = r10 ? {22'h0, codes[ch]} : {24'h0, codes[ch][9:2]};
	endfunction

	task automatic wait_idle(output int n);
		n = 0;
		while (conv_busy === 1'b1 && n < 20000) begin
			@(posedge pclk);
			n++;
		end
	endtask

	// Sample strobe cycles, cleared at each run
	always @(posedge pclk) begin
		if (conv_sample === 1'b1) begin
			smp++;
		end
	end

	task automatic run(input logic [31:0] cv, output int n);
		int t;
		smp = 0;
		apb(1'b1, OFF_CTRL, cv);
		t = 0;
		while (conv_busy !== 1'b1 && t < 30) begin
			@(posedge pclk);
			t++;
		end
		wait_idle(n);
		@(posedge pclk);
	endtask

	initial begin
		repeat (50000) @(posedge pclk);
		err_count++;
		print_verdict();
	end

	initial begin
		s = $urandom(32'ha75c_8905);
		{presetn, psel, penable, pwrite, trig} = 5'b00001;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		foreach (codes[i]) codes[i] = 10'($urandom);
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFF_CTRL, 32'h0000_0800, 1'b0);
		rd(OFF_STATUS, 32'h0000_0000, 1'b0);
		rd(8'h10, 32'h0000_0000, 1'b1);
		// Four-channel sweep with the interrupt masked; pclk is above 10 MHz, so divide
		run(ctrl(0, MODE_SWEEP, 0, 1, 1, 1, 1), c);
		chk_cnt(c, 4 * 33 * 2);
		chk_cnt(smp, 4 * 2);
		for (int i = 0; i < 4; i++) rd(OFF_RESULT + 8'(4 * i), rexp(i, 1), 1'b0);
		rd(OFF_RESULT + 8'h10, 32'h0000_0000, 1'b0);
		rd(OFF_CTRL, ctrl(0, MODE_SWEEP, 0, 1, 1, 1, 1) & 32'hffff_ffbf, 1'b0);
		rd(OFF_STATUS, 32'h0000_0001, 1'b0);
		chk_rd({32'h0, irq}, 33'h0);
		apb(1'b1, OFF_MASK, 32'h0000_0001);
		// irq follows the mask one cycle after the write lands
		@(negedge pclk);
		@(negedge pclk);
		chk_rd({32'h0, irq}, 33'h1);
		apb(1'b1, OFF_STATUS, 32'h0000_0001);
		@(negedge pclk);
		@(negedge pclk);
		chk_rd({32'h0, irq}, 33'h0);
		// Every divider, both resolutions, with and without sample-hold
		for (int f = 0; f < 6; f++) begin
			foreach (codes[i]) codes[i] = 10'($urandom);
			run(ctrl(0, MODE_SWEEP, 0, 3'(f), f[0], f[1], 0), c);
			chk_cnt(c, 2 * nn[f % 4] * dv[f]);
			rd(OFF_RESULT + 8'h04, rexp(1, f[0]), 1'b0);
			apb(1'b1, OFF_STATUS, 32'h0000_0001);
		end
		for (int ch = 0; ch < 8; ch++) begin
			run(ctrl(3'(ch), MODE_ONE_SHOT, 0, 1, 1, 1, 0), c);
			chk_cnt(c, 33 * 2);
			rd(OFF_RESULT + 8'(4 * ch), rexp(ch, 1), 1'b0);
		end
		// Divider change mid-sweep must not stretch the running sweep
		fork
			run(ctrl(0, MODE_SWEEP, 0, 1, 1, 1, 0), c);
			begin
				repeat (20) @(posedge pclk);
				apb(1'b1, OFF_CTRL, ctrl(0, MODE_SWEEP, 0, 5, 1, 1, 0));
			end
		join
		chk_cnt(c, 2 * 33 * 2);
		// External start, then a retrigger partway through
		apb(1'b1, OFF_CTRL, ctrl(0, MODE_SWEEP, 1, 1, 1, 1, 0));
		repeat (10) @(posedge pclk);
		chk_rd({32'h0, conv_busy}, 33'h0);
		trig <= 1'b0;
		repeat (20) @(posedge pclk);
		trig <= 1'b1;
		@(posedge pclk);
		trig <= 1'b0;
		@(posedge pclk);
		wait_idle(c);
		chk_cnt(c, 2 * 33 * 2);
		rd(OFF_RESULT, rexp(0, 1), 1'b0);
		trig <= 1'b1;
		repeat (4) @(posedge pclk);
		// Repeat and both repeat sweeps run until start is cleared
		for (int m = 1; m < 5; m++) begin
			if (m != 2) begin
				foreach (codes[i]) codes[i] = 10'($urandom);
				apb(1'b1, OFF_STATUS, 32'h0000_0001);
				apb(1'b1, OFF_CTRL, ctrl(5, 3'(m), 0, 1, 1, 1, 0));
				repeat (300) @(posedge pclk);
				rd(OFF_STATUS, {30'h0, 1'b1, m != 1}, 1'b0);
				rd(OFF_RESULT + 8'(m == 1 ? 20 : 4), rexp(m == 1 ? 5 : 1, 1), 1'b0);
				apb(1'b1, OFF_CTRL, 32'h0000_0800);
				wait_idle(c);
				chk_cnt(c, 3);
			end
		end
		print_verdict();
	end
endmodule // adc_sweep_sequencer_bench

// ### dv/analog_front_model.sv
// Front-end stand-in: one fixed code per input channel.
// Assumes the bench loads chan_code and holds it during a sweep.
`timescale 1ns/1ns
module analog_front_model (
	// Channel select
	input wire logic [adc_seq_pkg::CH_W-1:0] analog_channel_sel,
	// Code table and output
	input wire logic [adc_seq_pkg::RES_W-1:0] chan_code [8],
	output logic [adc_seq_pkg::RES_W-1:0] conv_code
);
	import adc_seq_pkg::*;
	// Held between samples; design samples at end of conversion
	assign conv_code = chan_code[analog_channel_sel];
endmodule // analog_front_model

// ### logic/adc_seq_pkg.sv
// Shared constants for the sweep sequencer: register map, fields, timing.
// Assumes a 32-bit APB slave with byte addresses on word boundaries.
package adc_seq_pkg;
	localparam int ADDR_W = 8;
	localparam int RES_W = 10;
	localparam int CH_W = 3;
	localparam int CNT_W = 7;
	localparam int DIV_W = 4;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_MASK = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_RESULT = 8'h20;
	localparam logic [ADDR_W-1:0] RESULT_MASK = 8'hE0;

	// Control fields
	localparam int F_CHAN = 0;
	localparam int F_MODE = 3;
	localparam int F_START = 6;
	localparam int F_EXT = 7;
	localparam int F_FREQ = 8;
	localparam int F_RES10 = 11;
	localparam int F_SH = 12;
	localparam int F_SWEEP = 13;
	localparam int MODE_W = 3;
	localparam int FREQ_W = 3;
	localparam int SWEEP_W = 2;
	localparam int CTRL_W = 15;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 15'h0800;

	// Status fields
	localparam int F_DONE = 0;
	localparam int F_BUSY = 1;

	// Converter clock cycles per channel
	localparam logic [CNT_W-1:0] CYC_8 = 7'd49;
	localparam logic [CNT_W-1:0] CYC_10 = 7'd59;
	localparam logic [CNT_W-1:0] CYC_8_SH = 7'd28;
	localparam logic [CNT_W-1:0] CYC_10_SH = 7'd33;

	// Divider minus one for each frequency select code
	localparam logic [DIV_W-1:0] DIV_1 = 4'h0;
	localparam logic [DIV_W-1:0] DIV_2 = 4'h1;
	localparam logic [DIV_W-1:0] DIV_3 = 4'h2;
	localparam logic [DIV_W-1:0] DIV_4 = 4'h3;
	localparam logic [DIV_W-1:0] DIV_6 = 4'h5;
	localparam logic [DIV_W-1:0] DIV_12 = 4'hB;

	typedef enum logic [MODE_W-1:0] {
		MODE_ONE_SHOT,
		MODE_REPEAT,
		MODE_SWEEP,
		MODE_REP_SWEEP0,
		MODE_REP_SWEEP1
	} mode_e;

	function automatic logic [DIV_W-1:0] div_m1(input logic [FREQ_W-1:0] sel);
		case (sel)
			3'h0: div_m1 = DIV_1;
			3'h1: div_m1 = DIV_2;
			3'h2: div_m1 = DIV_3;
			3'h3: div_m1 = DIV_4;
			3'h4: div_m1 = DIV_6;
			default: div_m1 = DIV_12;
		endcase
	endfunction

	function automatic logic [CNT_W-1:0] conv_last(input logic res10, input logic sh);
		logic [CNT_W-1:0] n;
		n = sh ? (res10 ? CYC_10_SH : CYC_8_SH) : (res10 ? CYC_10 : CYC_8);
		conv_last = n - 7'd1;
	endfunction
endpackage

// ### logic/adc_sweep_sequencer.sv
// Converter sequencer: APB registers, clock divider, trigger and sweep control.
// Assumes an analog front end that presents the selected channel's code on
// conv_code at the end of each conversion, where it is stored; all inputs synchronous to pclk.
`timescale 1ns/1ns
module adc_sweep_sequencer #(
	parameter int CHANNELS = 8
) (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [adc_seq_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Trigger pin
	input wire logic external_conversion_trigger,
	// Analog front end
	input wire logic [adc_seq_pkg::RES_W-1:0] conv_code,
	output logic [adc_seq_pkg::CH_W-1:0] analog_channel_sel,
	output logic conv_sample,
	output logic conv_busy,
	// Interrupt
	output logic irq
);
	import adc_seq_pkg::*;

	typedef enum logic {ST_IDLE, ST_CONV} state_e;

	result_if res_port();

	result_mem #(.DEPTH(CHANNELS)) u_mem (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.port(res_port)
	);

	logic [CTRL_W-1:0] ctrl_q;
	logic done_q;
	logic mask_q;
	logic irq_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic trig_prev_q;
	state_e state_q;
	logic [CH_W-1:0] chan_q;
	logic [CNT_W-1:0] cnt_q;
	logic [DIV_W-1:0] div_cnt_q;
	// Latched at start so a sweep never sees half-changed settings
	mode_e mode_lat_q;
	logic res10_lat_q;
	logic sh_lat_q;
	logic [DIV_W-1:0] div_lat_q;
	logic [CH_W-1:0] last_lat_q;
	logic [CH_W-1:0] sel_lat_q;

	logic access;
	logic fire;
	logic wr_fire;
	logic is_result;
	logic mapped;
	logic [31:0] rd_mux;
	logic start_q;
	logic ext_mode;
	logic sw_go;
	logic ext_go;
	logic go;
	logic tick;
	logic conv_end;
	logic sweep_lat;
	logic sweep_cfg;
	logic chan_last;
	logic finish;
	logic wrap_done;
	logic done_set;
	logic ctrl_write;
	logic [CTRL_W-1:0] ctrl_src;

	assign start_q = ctrl_q[F_START];
	assign ext_mode = ctrl_q[F_EXT];
	assign sweep_lat = mode_lat_q inside {MODE_SWEEP, MODE_REP_SWEEP0, MODE_REP_SWEEP1};
	// A starting write is taken from pwdata; ctrl_q still holds the old value then
	assign ctrl_src = ctrl_write ? pwdata[CTRL_W-1:0] : ctrl_q;
	assign sweep_cfg = ctrl_src[F_MODE +: MODE_W] inside {MODE_SWEEP, MODE_REP_SWEEP0,
		MODE_REP_SWEEP1};

	// APB handshake: one wait state, so result reads see the registered port
	assign access = psel && penable && !pready_q;
	assign fire = psel && penable && pready_q;
	assign wr_fire = fire && pwrite && !pslverr_q;
	assign is_result = (paddr & RESULT_MASK) == OFF_RESULT;
	assign mapped = is_result || paddr == OFF_CTRL || paddr == OFF_STATUS || paddr == OFF_MASK;
	assign ctrl_write = wr_fire && paddr == OFF_CTRL;

	always_comb begin
		rd_mux = '0;
		if (is_result) begin
			rd_mux[RES_W-1:0] = res_port.rdata;
		end else if (paddr == OFF_CTRL) begin
			rd_mux[CTRL_W-1:0] = ctrl_q;
		end else if (paddr == OFF_STATUS) begin
			rd_mux[F_DONE] = done_q;
			rd_mux[F_BUSY] = state_q == ST_CONV;
		end else if (paddr == OFF_MASK) begin
			rd_mux[F_DONE] = mask_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
		end else if (ce) begin
			pready_q <= access;
			if (access) begin
				pslverr_q <= !mapped;
				prdata_q <= rd_mux;
			end else begin
				pslverr_q <= 1'b0;
			end
		end
	end

	// Trigger decode
	assign sw_go = ctrl_write && pwdata[F_START] && !start_q && !pwdata[F_EXT];
	assign ext_go = ext_mode && start_q && trig_prev_q && !external_conversion_trigger;
	assign go = sw_go || ext_go;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_prev_q <= 1'b1;
		end else if (ce) begin
			trig_prev_q <= external_conversion_trigger;
		end
	end

	// Converter clock and per-channel cycle count
	assign tick = div_cnt_q == div_lat_q;
	assign conv_end = state_q == ST_CONV && tick && cnt_q == conv_last(res10_lat_q, sh_lat_q);
	assign chan_last = chan_q == last_lat_q;
	assign finish = conv_end && ((mode_lat_q == MODE_ONE_SHOT)
		|| (mode_lat_q == MODE_SWEEP && chan_last));
	assign wrap_done = conv_end && chan_last
		&& (mode_lat_q == MODE_REP_SWEEP0 || mode_lat_q == MODE_REP_SWEEP1);
	assign done_set = finish || wrap_done;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_q <= '0;
		end else if (ce) begin
			if (go || state_q != ST_CONV || tick) begin
				div_cnt_q <= '0;
			end else begin
				div_cnt_q <= div_cnt_q + 4'h1;
			end
		end
	end

	// Settings latch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_lat_q <= MODE_ONE_SHOT;
			res10_lat_q <= 1'b1;
			sh_lat_q <= 1'b0;
			div_lat_q <= DIV_1;
			last_lat_q <= '0;
			sel_lat_q <= '0;
		end else if (ce && go) begin
			mode_lat_q <= mode_e'(ctrl_src[F_MODE +: MODE_W]);
			res10_lat_q <= ctrl_src[F_RES10];
			sh_lat_q <= ctrl_src[F_SH];
			div_lat_q <= div_m1(ctrl_src[F_FREQ +: FREQ_W]);
			last_lat_q <= {ctrl_src[F_SWEEP +: SWEEP_W], 1'b1};
			sel_lat_q <= ctrl_src[F_CHAN +: CH_W];
		end
	end

	// Sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			chan_q <= '0;
			cnt_q <= '0;
		end else if (ce) begin
			if (go) begin
				state_q <= ST_CONV;
				chan_q <= sweep_cfg ? '0 : ctrl_src[F_CHAN +: CH_W];
				cnt_q <= '0;
			end else if (state_q == ST_CONV) begin
				if (!start_q || finish) begin
					state_q <= ST_IDLE;
					cnt_q <= '0;
				end else if (conv_end) begin
					cnt_q <= '0;
					if (sweep_lat) begin
						chan_q <= chan_last ? '0 : chan_q + 3'd1;
					end else begin
						chan_q <= sel_lat_q;
					end
				end else if (tick) begin
					cnt_q <= cnt_q + 7'd1;
				end
			end
		end
	end

	// Result store: one word per channel, 8-bit results right-aligned
	assign res_port.we = ce && conv_end;
	assign res_port.waddr = chan_q;
	assign res_port.wdata = res10_lat_q ? conv_code : {2'b00, conv_code[RES_W-1:2]};
	assign res_port.raddr = paddr[2 +: CH_W];

	// Control register; hardware clear of start loses to a software write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RESET;
		end else if (ce) begin
			if (ctrl_write) begin
				ctrl_q <= pwdata[CTRL_W-1:0];
			end else if (finish) begin
				ctrl_q[F_START] <= 1'b0;
			end
		end
	end

	// Status and mask; a completion in the clearing cycle is kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_q <= 1'b0;
		end else if (ce) begin
			if (done_set) begin
				done_q <= 1'b1;
			end else if (wr_fire && paddr == OFF_STATUS && pwdata[F_DONE]) begin
				done_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= 1'b0;
		end else if (ce && wr_fire && paddr == OFF_MASK) begin
			mask_q <= pwdata[F_DONE];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else if (ce) begin
			irq_q <= done_q && mask_q;
		end
	end

	// Front-end drive
	logic [CH_W-1:0] sel_out_q;
	logic sample_q;
	logic busy_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_out_q <= '0;
			sample_q <= 1'b0;
			busy_q <= 1'b0;
		end else if (ce) begin
			sel_out_q <= chan_q;
			sample_q <= state_q == ST_CONV && cnt_q == '0;
			busy_q <= state_q == ST_CONV;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign analog_channel_sel = sel_out_q;
	assign conv_sample = sample_q;
	assign conv_busy = busy_q;
	assign irq = irq_q;

	// Checks
	a_irq_from_status: assert property (@(posedge pclk) disable iff (!presetn)
		ce |=> irq_q == $past(done_q && mask_q)) else $error("irq not tracking done and mask");

	a_conv_cycle_count: assert property (@(posedge pclk) disable iff (!presetn)
		res_port.we |-> cnt_q == (sh_lat_q ? (res10_lat_q ? CYC_10_SH : CYC_8_SH)
		: (res10_lat_q ? CYC_10 : CYC_8)) - 7'd1) else $error("conversion length wrong");

	a_sh_short_count: assert property (@(posedge pclk) disable iff (!presetn)
		(res_port.we && sh_lat_q && !res10_lat_q) |-> cnt_q == 7'd27)
		else $error("sample-hold 8-bit length wrong");

	a_sweep_ascends: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && conv_end && sweep_lat && !chan_last && start_q && !go)
		|=> chan_q == $past(chan_q) + 3'd1) else $error("sweep order broken");

	a_sweep_clears_start: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && finish && !ctrl_write && !go) |=> !start_q && state_q == ST_IDLE)
		else $error("sweep did not stop");

	a_done_on_sweep: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && done_set) |=> done_q ##1 (!ce || irq_q || !mask_q || !done_q))
		else $error("completion not flagged");

	a_ext_restart: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && ext_go) |=> state_q == ST_CONV && cnt_q == '0 && div_cnt_q == '0)
		else $error("external edge did not restart");

	a_sw_start: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && sw_go) |=> state_q == ST_CONV) else $error("software start ignored");

	a_cfg_frozen: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == ST_CONV && !go) |=> $stable(res10_lat_q) && $stable(div_lat_q)
		&& $stable(mode_lat_q)) else $error("settings changed mid conversion");

	a_result_high_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(pready_q && is_result) |-> prdata_q[31:RES_W] == '0) else $error("result upper bits set");

	a_div_spacing: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && state_q == ST_CONV && tick && !go && div_lat_q == DIV_3)
		|=> !tick ##1 (!tick || div_lat_q != DIV_3)) else $error("divider tick spacing wrong");

	c_single_sweep: cover property (@(posedge pclk) disable iff (!presetn)
		finish && mode_lat_q == MODE_SWEEP);
	c_ext_retrigger: cover property (@(posedge pclk) disable iff (!presetn)
		ext_go && state_q == ST_CONV);
	c_sweep_wrap: cover property (@(posedge pclk) disable iff (!presetn) wrap_done);
endmodule // adc_sweep_sequencer

// ### logic/result_if.sv
// Result store port between sequencer and its per-channel result memory.
// Assumes one writer and one registered reader on the same clock.
`timescale 1ns/1ns
interface result_if;
	logic we;
	logic [adc_seq_pkg::CH_W-1:0] waddr;
	logic [adc_seq_pkg::RES_W-1:0] wdata;
	logic [adc_seq_pkg::CH_W-1:0] raddr;
	logic [adc_seq_pkg::RES_W-1:0] rdata;
	modport writer(output we, output waddr, output wdata, output raddr, input rdata);
	modport store(input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ### logic/result_mem.sv
// One result word per channel, registered read port.
// Assumes writer and reader share pclk; ce freezes it.
`timescale 1ns/1ns
module result_mem #(
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Access port
	result_if.store port
);
	import adc_seq_pkg::*;

	logic [RES_W-1:0] mem_q [DEPTH];
	logic [RES_W-1:0] rdata_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else if (ce && port.we) begin
			mem_q[port.waddr] <= port.wdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= '0;
		end else if (ce) begin
			rdata_q <= mem_q[port.raddr];
		end
	end

	assign port.rdata = rdata_q;
endmodule // result_mem
